// file: hdl/rll_pkg.sv
// Overview of operation
// - each byte plus current state looks up one 16-bit word and next state
// - code word bit 15 is msb and leaves the serial channel first
// - joined code words keep 2 to 10 zeros between any two ones
// - words leaving state 2 have bit 15 and bit 3 both zero
// - words leaving state 3 have bit 15 or bit 3 set
// - zero or one trailing zero goes to state 1; state 1 words lead 2-9 zeros
// - two to five trailing zeros go to state 2 or 3; state 2 leads 1-5
// - state 3 words lead 0-5 zeros; entered after 2-5 trailing zeros
// - six to nine trailing zeros go to state 4; state 4 leads 0-1 zeros
// - identical words from one state split between next states 2 and 3
package rll_pkg;

  localparam int BYTE_W     = 8;
  localparam int WORD_W     = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int BIT_CNT_W  = 4;
  localparam int MSB_POS    = WORD_W - 1;
  localparam int MARK_POS   = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hf;

  typedef enum logic [1:0] {
    ST1,
    ST2,
    ST3,
    ST4
  } rll_state_type;

  localparam rll_state_type RESET_STATE = ST1;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    rll_state_type     next;
  } rll_entry_type;

endpackage

// file: hdl/rll_fifo.sv
`timescale 1ns/10ps
module rll_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];

  always_comb begin
    push  = in_valid & in_ready;
    pop   = out_valid & out_ready;
    wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop & ~push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // rll_fifo

// file: hdl/rll_encoder.sv
`timescale 1ns/10ps
module rll_encoder (
  input  wire logic                             CLK_SYS,
  input  wire logic                             RST,
  input  wire logic [rll_pkg::BYTE_W-1:0]       DATA_IN,
  input  wire logic                             DATA_VALID,
  output logic                                  DATA_READY,
  input  wire logic                             START_LOAD,
  input  wire rll_pkg::rll_state_type           START_STATE,
  output rll_pkg::rll_state_type                ENC_STATE,
  output logic                                  CHAN_BIT,
  output logic                                  CHAN_VALID,
  output logic                                  CHAN_WORD_FIRST
);
  import rll_pkg::*;

  // constant conversion rom; unlisted pairs fall back to a safe word per state
  function automatic rll_entry_type lookup(input rll_state_type st,
                                           input logic [BYTE_W-1:0] b);
    rll_entry_type e;
    e = '{word: 16'h0000, next: ST1};
    case (st)
      ST1: begin // lead 2-9 zeros
        case (b)
          8'h02:   e = '{word: 16'h2120, next: ST2};
          8'h04:   e = '{word: 16'h2090, next: ST2};
          8'h08:   e = '{word: 16'h2090, next: ST3};
          8'h09:   e = '{word: 16'h2120, next: ST3};
          8'h0a:   e = '{word: 16'h2480, next: ST4};
          8'h0b:   e = '{word: 16'h2240, next: ST4};
          8'h0c:   e = '{word: 16'h2481, next: ST1};
          8'h0d:   e = '{word: 16'h2241, next: ST1};
          8'h0f:   e = '{word: 16'h2121, next: ST1};
          8'h10:   e = '{word: 16'h2091, next: ST1};
          8'h16:   e = '{word: 16'h0401, next: ST1};
          8'h17:   e = '{word: 16'h2220, next: ST2};
          8'h18:   e = '{word: 16'h2110, next: ST2};
          8'h19:   e = '{word: 16'h2088, next: ST2};
          8'h1b:   e = '{word: 16'h1120, next: ST2};
          8'h1d:   e = '{word: 16'h1090, next: ST2};
          8'h1e:   e = '{word: 16'h1048, next: ST2};
          default: e = '{word: 16'h2024, next: ST2};
        endcase
      end
      ST2: begin // bits 15 and 3 clear
        case (b)
          8'h00:   e = '{word: 16'h4120, next: ST2};
          8'h02:   e = '{word: 16'h2120, next: ST2};
          8'h03:   e = '{word: 16'h4480, next: ST4};
          8'h04:   e = '{word: 16'h2090, next: ST2};
          8'h07:   e = '{word: 16'h4012, next: ST1};
          8'h08:   e = '{word: 16'h2090, next: ST3};
          8'h09:   e = '{word: 16'h2120, next: ST3};
          8'h0a:   e = '{word: 16'h2480, next: ST4};
          8'h0b:   e = '{word: 16'h2240, next: ST4};
          8'h0c:   e = '{word: 16'h2481, next: ST1};
          8'h0d:   e = '{word: 16'h2241, next: ST1};
          8'h0e:   e = '{word: 16'h4024, next: ST3};
          8'h0f:   e = '{word: 16'h2121, next: ST1};
          8'h10:   e = '{word: 16'h2091, next: ST1};
          8'h13:   e = '{word: 16'h2011, next: ST1};
          8'h15:   e = '{word: 16'h0802, next: ST1};
          8'h16:   e = '{word: 16'h0401, next: ST1};
          default: e = '{word: 16'h4120, next: ST2};
        endcase
      end
      ST3: begin // bit 15 or bit 3 set
        case (b)
          8'h01:   e = '{word: 16'h8120, next: ST3};
          8'h02:   e = '{word: 16'h8012, next: ST1};
          8'h04:   e = '{word: 16'h8120, next: ST2};
          8'h05:   e = '{word: 16'h9200, next: ST4};
          8'h06:   e = '{word: 16'h8900, next: ST4};
          8'h08:   e = '{word: 16'h8480, next: ST4};
          8'h09:   e = '{word: 16'h9201, next: ST1};
          8'h0a:   e = '{word: 16'h8901, next: ST1};
          8'h0d:   e = '{word: 16'h8481, next: ST1};
          8'h0f:   e = '{word: 16'h8241, next: ST1};
          8'h10:   e = '{word: 16'h8121, next: ST1};
          8'h11:   e = '{word: 16'h8240, next: ST4};
          8'h12:   e = '{word: 16'h1009, next: ST1};
          8'h13:   e = '{word: 16'h9100, next: ST4};
          8'h15:   e = '{word: 16'h8091, next: ST1};
          8'h16:   e = '{word: 16'h8049, next: ST1};
          8'h17:   e = '{word: 16'h8048, next: ST2};
          8'h18:   e = '{word: 16'h8048, next: ST3};
          default: e = '{word: 16'h8120, next: ST2};
        endcase
      end
      ST4: begin // lead 0-1 zeros
        case (b)
          8'h00:   e = '{word: 16'h4120, next: ST2};
          8'h01:   e = '{word: 16'h8120, next: ST3};
          8'h03:   e = '{word: 16'h4480, next: ST4};
          8'h04:   e = '{word: 16'h8120, next: ST2};
          8'h06:   e = '{word: 16'h8900, next: ST4};
          8'h08:   e = '{word: 16'h8480, next: ST4};
          8'h0a:   e = '{word: 16'h8901, next: ST1};
          8'h0d:   e = '{word: 16'h8481, next: ST1};
          8'h0f:   e = '{word: 16'h8241, next: ST1};
          8'h10:   e = '{word: 16'h8121, next: ST1};
          8'h11:   e = '{word: 16'h8240, next: ST4};
          8'h12:   e = '{word: 16'h4090, next: ST2};
          8'h13:   e = '{word: 16'h9100, next: ST4};
          default: e = '{word: 16'h8120, next: ST2};
        endcase
      end
      default: e = '{word: 16'h2024, next: ST2};
    endcase
    return e;
  endfunction

  // encode stage
  rll_state_type     state_q;
  rll_state_type     state_d;
  logic [WORD_W-1:0] stg_word_q;
  logic [WORD_W-1:0] stg_word_d;
  logic              stg_valid_q;
  logic              stg_valid_d;
  logic              rdy_q;
  logic              rdy_d;
  rll_entry_type     hit;
  logic              take;
  logic              push;
  logic              fifo_in_ready;
  logic [WORD_W-1:0] fifo_word;
  logic              fifo_valid;
  logic              fifo_pop;

  always_comb begin
    hit         = lookup(state_q, DATA_IN);
    take        = DATA_VALID & rdy_q;
    push        = stg_valid_q & fifo_in_ready;
    stg_word_d  = take ? hit.word : stg_word_q;
    stg_valid_d = take | (stg_valid_q & ~push);
    // one bubble per byte is harmless: a word takes sixteen cycles to leave
    rdy_d       = ~stg_valid_d;
    state_d     = state_q;
    if (START_LOAD) begin
      state_d = START_STATE;
    end else if (take) begin
      state_d = hit.next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_q     <= RESET_STATE;
      stg_word_q  <= '0;
      stg_valid_q <= 1'b0;
      rdy_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      stg_word_q  <= stg_word_d;
      stg_valid_q <= stg_valid_d;
      rdy_q       <= rdy_d;
    end
  end

  assign DATA_READY = rdy_q;
  assign ENC_STATE  = state_q;

  rll_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst       (RST),
    .in_data   (stg_word_q),
    .in_valid  (stg_valid_q),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // serializer
  logic [WORD_W-1:0]    shift_q;
  logic [WORD_W-1:0]    shift_d;
  logic [BIT_CNT_W-1:0] cnt_q;
  logic [BIT_CNT_W-1:0] cnt_d;
  logic                 busy_q;
  logic                 busy_d;
  logic                 bit_q;
  logic                 bit_d;
  logic                 first_q;
  logic                 first_d;

  always_comb begin
    fifo_pop = fifo_valid & (~busy_q | (cnt_q == LAST_BIT));
    shift_d  = shift_q;
    cnt_d    = cnt_q;
    busy_d   = busy_q;
    bit_d    = bit_q;
    first_d  = 1'b0;
    if (fifo_pop) begin
      bit_d   = fifo_word[MSB_POS];
      shift_d = {fifo_word[MSB_POS-1:0], 1'b0};
      cnt_d   = '0;
      busy_d  = 1'b1;
      first_d = 1'b1;
    end else if (busy_q && cnt_q != LAST_BIT) begin
      bit_d   = shift_q[MSB_POS];
      shift_d = {shift_q[MSB_POS-1:0], 1'b0};
      cnt_d   = BIT_CNT_W'(cnt_q + 1'b1);
    end else begin
      // underrun breaks the channel; the framer must keep the fifo fed
      busy_d  = 1'b0;
      bit_d   = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      shift_q <= '0;
      cnt_q   <= '0;
      busy_q  <= 1'b0;
      bit_q   <= 1'b0;
      first_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      busy_q  <= busy_d;
      bit_q   <= bit_d;
      first_q <= first_d;
    end
  end

  assign CHAN_BIT        = bit_q;
  assign CHAN_VALID      = busy_q;
  assign CHAN_WORD_FIRST = first_q;
endmodule // rll_encoder

// file: tb/rll_chan_sink.sv
`timescale 1ns/10ps
module rll_chan_sink (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        chan_bit,
  input  wire logic        chan_valid,
  input  wire logic        word_first,
  output logic [15:0]      word,
  output logic             word_done
);
  logic [3:0] cnt;
  // no back-pressure exists on the channel, so the sink just listens
  always_ff @(posedge clk) begin
    word_done <= 1'b0;
    if (rst) begin
      cnt <= 4'h0;
    end else if (chan_valid) begin
      word      <= {word[14:0], chan_bit};
      cnt       <= word_first ? 4'h1 : cnt + 4'h1;
      word_done <= (cnt == 4'hf) && !word_first;
    end
  end
endmodule // rll_chan_sink

// file: tb/rll_encoder_asserts.sv
`timescale 1ns/10ps
module rll_encoder_asserts (
  input wire logic                   CLK_SYS,
  input wire logic                   RST,
  input wire logic [7:0]             DATA_IN,
  input wire logic                   DATA_VALID,
  input wire logic                   DATA_READY,
  input wire logic                   START_LOAD,
  input wire rll_pkg::rll_state_type START_STATE,
  input wire rll_pkg::rll_state_type ENC_STATE,
  input wire logic                   CHAN_BIT,
  input wire logic                   CHAN_VALID,
  input wire logic                   CHAN_WORD_FIRST
);
  import rll_pkg::*;
  logic [4:0] zrun_q, zrun_d;
  logic       seen_q, seen_d;
  // zeros counted only on valid bits, so underrun gaps do not count
  always_comb begin
    zrun_d = zrun_q;
    seen_d = seen_q;
    if (CHAN_VALID) begin
      zrun_d = CHAN_BIT ? 5'h0 : zrun_q + 5'h1;
      seen_d = seen_q | CHAN_BIT;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    zrun_q <= RST ? 5'h0 : zrun_d;
    seen_q <= RST ? 1'b0 : seen_d;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_min_zero_run: assert property (CHAN_VALID && CHAN_BIT && seen_q |-> zrun_q >= 5'h2)
    else $error("ones closer than two zeros");
  a_max_zero_run: assert property (seen_q |-> zrun_q <= 5'ha)
    else $error("zero run longer than ten");
  a_ready_drop: assert property (DATA_VALID && DATA_READY |=> !DATA_READY)
    else $error("ready stayed high after take");
  a_ready_back: assert property (DATA_VALID && DATA_READY |-> ##[2:400] DATA_READY)
    else $error("ready never returned");
  a_word_span: assert property (CHAN_WORD_FIRST |=> (CHAN_VALID && !CHAN_WORD_FIRST)[*8]
    ##1 (CHAN_VALID && !CHAN_WORD_FIRST)[*7]) else $error("word not sixteen bits");
  a_state_hold: assert property (!(DATA_VALID && DATA_READY) && !START_LOAD
    |=> $stable(ENC_STATE)) else $error("state moved without byte");
  a_sync_load: assert property (START_LOAD |=> ENC_STATE == $past(START_STATE))
    else $error("start state not loaded");
  a_reset_init: assert property (disable iff (1'b0) RST
    |=> ENC_STATE == ST1 && !DATA_READY && !CHAN_VALID) else $error("reset values wrong");
endmodule // rll_encoder_asserts
bind rll_encoder rll_encoder_asserts u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .DATA_IN(DATA_IN),
  .DATA_VALID(DATA_VALID), .DATA_READY(DATA_READY), .START_LOAD(START_LOAD),
  .START_STATE(START_STATE), .ENC_STATE(ENC_STATE), .CHAN_BIT(CHAN_BIT),
  .CHAN_VALID(CHAN_VALID), .CHAN_WORD_FIRST(CHAN_WORD_FIRST));

// file: tb/rll_encoder_bench.sv
`timescale 1ns/10ps
`define CHK(a,b) begin total_checks++; if ((a)!==(b)) begin bad_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module rll_encoder_bench;
  import rll_pkg::*;
  logic          clk_sys = 1'b0, rst = 1'b1, data_valid = 1'b0, start_load = 1'b0;
  logic [7:0]    data_in = 8'h00;
  rll_state_type start_state = ST1, enc_state;
  logic          data_ready, chan_bit, chan_valid, chan_word_first, word_done;
  logic [15:0]   word, exp_w, exp_q[$], rx[$];
  int            bad_count = 0, total_checks = 0, max_wait = 0;
  always #25 clk_sys = ~clk_sys;
  rll_encoder dut (.CLK_SYS(clk_sys), .RST(rst), .DATA_IN(data_in), .DATA_VALID(data_valid),
    .DATA_READY(data_ready), .START_LOAD(start_load), .START_STATE(start_state),
    .ENC_STATE(enc_state), .CHAN_BIT(chan_bit), .CHAN_VALID(chan_valid),
    .CHAN_WORD_FIRST(chan_word_first));
  rll_chan_sink sink (.clk(clk_sys), .rst(rst), .chan_bit(chan_bit), .chan_valid(chan_valid),
    .word_first(chan_word_first), .word(word), .word_done(word_done));
  always @(posedge clk_sys) if (word_done) begin
    rx.push_back(word);
    `CHK(exp_q.size() != 0, 1'b1)
    if (exp_q.size() != 0) exp_w = exp_q.pop_front();
    `CHK(word, exp_w)
  end
  task end_sim;
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task send(input logic [7:0] b, input logic [15:0] w, input rll_state_type s);
    int n;
    n = 0;
    data_in <= b;
    data_valid <= 1'b1;
    exp_q.push_back(w);
    do begin @(posedge clk_sys); n++; end while (data_ready !== 1'b1 && n < 500);
    `CHK(data_ready, 1'b1)
    data_valid <= 1'b0;
    if (n > max_wait) max_wait = n;
    @(posedge clk_sys);
    `CHK(enc_state, s)
  endtask
  task drain;
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 3000) begin @(posedge clk_sys); n++; end
    repeat (3) @(posedge clk_sys);
    `CHK(exp_q.size(), 0)
  endtask
  task t_reset;
    repeat (20) @(posedge clk_sys);
    `CHK({data_ready, enc_state, chan_valid}, {1'b0, ST1, 1'b0})
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task t_sync;
    start_load <= 1'b1;
    start_state <= ST3;
    @(posedge clk_sys);
    start_load <= 1'b0;
    @(posedge clk_sys);
    `CHK(enc_state, ST3)
    send(8'h0d, 16'h8481, ST1);
  endtask
  task t_walk;
    send(8'h02, 16'h2120, ST2);
    send(8'h03, 16'h4480, ST4);
    send(8'h01, 16'h8120, ST3);
    send(8'h02, 16'h8012, ST1);
  endtask
  task t_twin;
    send(8'h04, 16'h2090, ST2);
    send(8'h00, 16'h4120, ST2);
    send(8'h0c, 16'h2481, ST1);
    send(8'h08, 16'h2090, ST3);
    send(8'h01, 16'h8120, ST3);
    drain;
    `CHK(rx[5], rx[8])
    `CHK({rx[6][15], rx[6][3]}, 2'b00)
    `CHK(|{rx[9][15], rx[9][3]}, 1'b1)
  endtask
  task t_fill;
    max_wait = 0;
    repeat (22) send(8'h01, 16'h8120, ST3);
    `CHK(max_wait > 8, 1'b1)
    drain;
  endtask
  initial begin
    t_reset;
    t_sync;
    t_walk;
    t_twin;
    t_fill;
    end_sim;
  end
  initial begin
    #1000000;
    bad_count++;
    end_sim;
  end
endmodule // rll_encoder_bench
